// ---- hw/pwm_unit_pkg.sv ----
package pwm_unit_pkg;
	localparam int NUM_GEN = 3;
	localparam int NUM_OUT = 6;
	localparam int CNT_W = 16;
	localparam int DB_W = 12;
	localparam int EV_W = 6;
	localparam int CTL_W = 6;
	localparam int ADDR_W = 12;
	// Global register byte offsets
	localparam logic [11:0] OFS_CTL = 12'h000;
	localparam logic [11:0] OFS_SYNC = 12'h004;
	localparam logic [11:0] OFS_ENABLE = 12'h008;
	localparam logic [11:0] OFS_INVERT = 12'h00c;
	localparam logic [11:0] OFS_FAULT = 12'h010;
	localparam logic [11:0] OFS_INTEN = 12'h014;
	localparam logic [11:0] OFS_RIS = 12'h018;
	localparam logic [11:0] OFS_ISC = 12'h01c;
	localparam logic [11:0] OFS_STATUS = 12'h020;
	// Generator g sits at 0x040 * (g + 1); offsets within a generator
	localparam logic [5:0] GOFS_CTL = 6'h00;
	localparam logic [5:0] GOFS_INTEN = 6'h04;
	localparam logic [5:0] GOFS_RIS = 6'h08;
	localparam logic [5:0] GOFS_ISC = 6'h0c;
	localparam logic [5:0] GOFS_LOAD = 6'h10;
	localparam logic [5:0] GOFS_COUNT = 6'h14;
	localparam logic [5:0] GOFS_CMPA = 6'h18;
	localparam logic [5:0] GOFS_CMPB = 6'h1c;
	localparam logic [5:0] GOFS_GENA = 6'h20;
	localparam logic [5:0] GOFS_GENB = 6'h24;
	localparam logic [5:0] GOFS_DBCTL = 6'h28;
	localparam logic [5:0] GOFS_DBRISE = 6'h2c;
	localparam logic [5:0] GOFS_DBFALL = 6'h30;
	// Generator control fields
	localparam int CTL_EN = 0;
	localparam int CTL_UPDOWN = 1;
	localparam int CTL_DBG_RUN = 2;
	localparam int CTL_LOAD_SYNC = 3;
	localparam int CTL_CMPA_SYNC = 4;
	localparam int CTL_CMPB_SYNC = 5;
	// Event bits; action field of event e is bits [2e+1:2e]
	localparam int EV_ZERO = 0;
	localparam int EV_LOAD = 1;
	localparam int EV_AUP = 2;
	localparam int EV_ADN = 3;
	localparam int EV_BUP = 4;
	localparam int EV_BDN = 5;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_LOW = 2'h2;
	localparam logic [1:0] ACT_HIGH = 2'h3;
	localparam int INTEN_FAULT = 16;
	localparam logic [31:0] RESET_VAL = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage

// ---- hw/multi_generator_pwm_unit.sv ----
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// Contract
// - Three generators: counter, two comparators, generator, deadband
// - Down mode: load to zero, reload, repeat
// - Up/down mode: zero to load and back
// - Direction low in down mode, follows counting
// - One-cycle zero and load pulses
// - Match pulses, direction qualified in up/down
// - Match above load never pulses
// - Four or six events per mode
// - Compare events ignored on zero or load
// - Coinciding A/B: each output uses own
// - Per-event action: none, toggle, low, high
// - Dead-band off: outputs pass unchanged
// - Dead-band on: first output rising delayed
// - Second output inverted, delayed after fall
// - Any enabled event subset raises interrupt
// - Interrupts from raw counter events
// - Sync reset of chosen counters together
// - Immediate update applies at next zero
// - Sync update waits for request, then zero
// - Update mode chosen per generator
// - Per-output fault forcing, fault interrupt
// - Stall: run on, or stop at zero
// - Per-output pin enable and inversion
module multi_generator_pwm_unit (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [pwm_unit_pkg::ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [pwm_unit_pkg::ADDR_W-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic i_fault,
	input wire logic i_stall,
	output logic [pwm_unit_pkg::NUM_OUT-1:0] o_pwm,
	output logic [pwm_unit_pkg::NUM_GEN-1:0] o_gen_irq,
	output logic o_fault_irq
);
	import pwm_unit_pkg::*;

	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = data[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Generator index of an address, 2'h3 for the global page or beyond
	function automatic logic [1:0] gen_of(input logic [11:0] a);
		logic [1:0] r;
		r = 2'h3;
		if (a[11:8] == 4'h0 && a[7:6] != 2'h0) begin
			r = a[7:6] - 2'h1;
		end
		return r;
	endfunction

	function automatic logic apply_act(input logic [1:0] act,
		input logic v);
		logic r;
		r = v;
		case (act)
			ACT_TOGGLE: r = ~v;
			ACT_LOW: r = 1'b0;
			ACT_HIGH: r = 1'b1;
			default: r = v;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	logic aw_hold, w_hold, wr_fire;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] rd_val;
	logic [1:0] wr_gen;
	logic [5:0] wr_ofs;
	logic wr_glob;

	logic [2:0] fault_ff, stall_ff;
	logic fault_s, stall_s;

	logic [NUM_GEN-1:0] upd_armed, sync_rst;
	logic [NUM_OUT-1:0] out_en, out_inv, fault_en;
	logic [NUM_GEN-1:0] glob_ien;
	logic fault_ien, fault_ris;

	logic [CTL_W-1:0] gctl [NUM_GEN];
	logic [EV_W-1:0] gien [NUM_GEN];
	logic [EV_W-1:0] gris [NUM_GEN];
	logic [CNT_W-1:0] load_sh [NUM_GEN];
	logic [CNT_W-1:0] cmpa_sh [NUM_GEN];
	logic [CNT_W-1:0] cmpb_sh [NUM_GEN];
	logic [CNT_W-1:0] load_act [NUM_GEN];
	logic [CNT_W-1:0] cmpa_act [NUM_GEN];
	logic [CNT_W-1:0] cmpb_act [NUM_GEN];
	logic [2*EV_W-1:0] gena [NUM_GEN];
	logic [2*EV_W-1:0] genb [NUM_GEN];
	logic [NUM_GEN-1:0] db_en;
	logic [DB_W-1:0] db_rise [NUM_GEN];
	logic [DB_W-1:0] db_fall [NUM_GEN];
	logic [DB_W-1:0] cnt_r [NUM_GEN];
	logic [DB_W-1:0] cnt_f [NUM_GEN];

	logic [CNT_W-1:0] cnt [NUM_GEN];
	logic [NUM_GEN-1:0] dir, halted, gen_a, gen_b;
	logic [NUM_GEN-1:0] run, ev_zero;
	logic [NUM_GEN-1:0] upd_ld, upd_a, upd_b;
	logic [EV_W-1:0] ev [NUM_GEN];
	logic [CNT_W-1:0] eff_load [NUM_GEN];
	logic [NUM_GEN-1:0] next_gen_a, next_gen_b;
	logic [NUM_OUT-1:0] raw_out;

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: address and data taken in either order
	assign o_s_axi_awready = ~aw_hold;
	assign o_s_axi_wready = ~w_hold;
	assign o_s_axi_arready = ~o_s_axi_rvalid;
	assign o_s_axi_bresp = RESP_OKAY;
	assign o_s_axi_rresp = RESP_OKAY;
	assign wr_fire = aw_hold & w_hold & ~o_s_axi_bvalid;
	assign wr_gen = gen_of(aw_addr);
	assign wr_ofs = aw_addr[5:0];
	assign wr_glob = wr_fire & (aw_addr[11:6] == 6'h00);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			o_s_axi_bvalid <= 1'b0;
		end else begin
			if (i_s_axi_awvalid && !aw_hold) begin
				aw_hold <= 1'b1;
				aw_addr <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && !w_hold) begin
				w_hold <= 1'b1;
				w_data <= i_s_axi_wdata;
				w_strb <= i_s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
			end else if (i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		logic [1:0] g;
		logic [5:0] o;
		g = gen_of(i_s_axi_araddr);
		o = i_s_axi_araddr[5:0];
		rd_val = 32'h0000_0000;
		if (i_s_axi_araddr == OFS_CTL) begin
			rd_val[NUM_GEN-1:0] = upd_armed;
		end else if (i_s_axi_araddr == OFS_ENABLE) begin
			rd_val[NUM_OUT-1:0] = out_en;
		end else if (i_s_axi_araddr == OFS_INVERT) begin
			rd_val[NUM_OUT-1:0] = out_inv;
		end else if (i_s_axi_araddr == OFS_FAULT) begin
			rd_val[NUM_OUT-1:0] = fault_en;
		end else if (i_s_axi_araddr == OFS_INTEN) begin
			rd_val[NUM_GEN-1:0] = glob_ien;
			rd_val[INTEN_FAULT] = fault_ien;
		end else if (i_s_axi_araddr == OFS_RIS) begin
			for (int k = 0; k < NUM_GEN; k++) begin
				rd_val[k] = |(gris[k] & gien[k]);
			end
			rd_val[INTEN_FAULT] = fault_ris;
		end else if (i_s_axi_araddr == OFS_ISC) begin
			rd_val[NUM_GEN-1:0] = o_gen_irq;
			rd_val[INTEN_FAULT] = o_fault_irq;
		end else if (i_s_axi_araddr == OFS_STATUS) begin
			rd_val[0] = fault_s;
		end else if (g != 2'h3) begin
			if (o == GOFS_CTL) begin
				rd_val[CTL_W-1:0] = gctl[g];
			end else if (o == GOFS_INTEN) begin
				rd_val[EV_W-1:0] = gien[g];
			end else if (o == GOFS_RIS) begin
				rd_val[EV_W-1:0] = gris[g];
			end else if (o == GOFS_ISC) begin
				rd_val[EV_W-1:0] = gris[g] & gien[g];
			end else if (o == GOFS_LOAD) begin
				rd_val[CNT_W-1:0] = load_sh[g];
			end else if (o == GOFS_COUNT) begin
				rd_val[CNT_W-1:0] = cnt[g];
			end else if (o == GOFS_CMPA) begin
				rd_val[CNT_W-1:0] = cmpa_sh[g];
			end else if (o == GOFS_CMPB) begin
				rd_val[CNT_W-1:0] = cmpb_sh[g];
			end else if (o == GOFS_GENA) begin
				rd_val[2*EV_W-1:0] = gena[g];
			end else if (o == GOFS_GENB) begin
				rd_val[2*EV_W-1:0] = genb[g];
			end else if (o == GOFS_DBCTL) begin
				rd_val[0] = db_en[g];
			end else if (o == GOFS_DBRISE) begin
				rd_val[DB_W-1:0] = db_rise[g];
			end else if (o == GOFS_DBFALL) begin
				rd_val[DB_W-1:0] = db_fall[g];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h0000_0000;
		end else if (i_s_axi_arvalid && !o_s_axi_rvalid) begin
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rdata <= rd_val;
		end else if (i_s_axi_rready) begin
			o_s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin inputs: the first stage is read only by the second
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fault_ff <= 3'h0;
			stall_ff <= 3'h0;
			fault_s <= 1'b0;
			stall_s <= 1'b0;
		end else begin
			fault_ff <= {fault_ff[1:0], i_fault};
			stall_ff <= {stall_ff[1:0], i_stall};
			if (fault_ff[1] == fault_ff[2]) begin
				fault_s <= fault_ff[2];
			end
			if (stall_ff[1] == stall_ff[2]) begin
				stall_s <= stall_ff[2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Global registers
	always_ff @(posedge i_clk) begin
		logic [31:0] d;
		d = wmerge(RESET_VAL, w_data, w_strb);
		if (i_rst) begin
			out_en <= '0;
			out_inv <= '0;
			fault_en <= '0;
			glob_ien <= '0;
			fault_ien <= 1'b0;
			sync_rst <= '0;
			upd_armed <= '0;
			fault_ris <= 1'b0;
		end else begin
			sync_rst <= '0;
			if (wr_glob && aw_addr == OFS_SYNC) begin
				sync_rst <= d[NUM_GEN-1:0];
			end
			if (wr_glob && aw_addr == OFS_ENABLE) begin
				out_en <= d[NUM_OUT-1:0];
			end
			if (wr_glob && aw_addr == OFS_INVERT) begin
				out_inv <= d[NUM_OUT-1:0];
			end
			if (wr_glob && aw_addr == OFS_FAULT) begin
				fault_en <= d[NUM_OUT-1:0];
			end
			if (wr_glob && aw_addr == OFS_INTEN) begin
				glob_ien <= d[NUM_GEN-1:0];
				fault_ien <= d[INTEN_FAULT];
			end
			// A request written in the applying cycle stays armed
			upd_armed <= (upd_armed & ~ev_zero) |
				((wr_glob && aw_addr == OFS_CTL) ?
				d[NUM_GEN-1:0] : '0);
			if (fault_s) begin
				fault_ris <= 1'b1;
			end else if (wr_glob && aw_addr == OFS_ISC) begin
				fault_ris <= fault_ris & ~d[INTEN_FAULT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Generator registers
	always_ff @(posedge i_clk) begin
		logic [31:0] d;
		d = wmerge(RESET_VAL, w_data, w_strb);
		if (i_rst) begin
			for (int k = 0; k < NUM_GEN; k++) begin
				gctl[k] <= '0;
				gien[k] <= '0;
				gris[k] <= '0;
				load_sh[k] <= '0;
				cmpa_sh[k] <= '0;
				cmpb_sh[k] <= '0;
				gena[k] <= '0;
				genb[k] <= '0;
				db_en[k] <= 1'b0;
				db_rise[k] <= '0;
				db_fall[k] <= '0;
			end
		end else begin
			for (int k = 0; k < NUM_GEN; k++) begin
				if (wr_fire && wr_gen == k[1:0]) begin
					if (wr_ofs == GOFS_CTL) gctl[k] <= d[CTL_W-1:0];
					if (wr_ofs == GOFS_INTEN) gien[k] <= d[EV_W-1:0];
					if (wr_ofs == GOFS_LOAD) load_sh[k] <= d[CNT_W-1:0];
					if (wr_ofs == GOFS_CMPA) cmpa_sh[k] <= d[CNT_W-1:0];
					if (wr_ofs == GOFS_CMPB) cmpb_sh[k] <= d[CNT_W-1:0];
					if (wr_ofs == GOFS_GENA) gena[k] <= d[2*EV_W-1:0];
					if (wr_ofs == GOFS_GENB) genb[k] <= d[2*EV_W-1:0];
					if (wr_ofs == GOFS_DBCTL) db_en[k] <= d[0];
					if (wr_ofs == GOFS_DBRISE) db_rise[k] <= d[DB_W-1:0];
					if (wr_ofs == GOFS_DBFALL) db_fall[k] <= d[DB_W-1:0];
				end
				// Raw events latch; a new event beats a clear
				gris[k] <= (gris[k] & ~((wr_fire && wr_gen == k[1:0] &&
					wr_ofs == GOFS_ISC) ? d[EV_W-1:0] : '0)) |
					ev[k];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Counter events and update decisions
	always_comb begin
		logic m_a, m_b, ud;
		m_a = 1'b0;
		m_b = 1'b0;
		ud = 1'b0;
		for (int k = 0; k < NUM_GEN; k++) begin
			ud = gctl[k][CTL_UPDOWN];
			run[k] = gctl[k][CTL_EN] & ~halted[k];
			ev_zero[k] = run[k] & (cnt[k] == '0);
			// Match beyond the load value never fires
			m_a = run[k] & (cnt[k] == cmpa_act[k]) &
				(cmpa_act[k] <= load_act[k]);
			m_b = run[k] & (cnt[k] == cmpb_act[k]) &
				(cmpb_act[k] <= load_act[k]);
			ev[k] = '0;
			ev[k][EV_ZERO] = ev_zero[k];
			ev[k][EV_LOAD] = run[k] & (cnt[k] == load_act[k]);
			ev[k][EV_AUP] = m_a & ud & dir[k];
			ev[k][EV_ADN] = m_a & ~(ud & dir[k]);
			ev[k][EV_BUP] = m_b & ud & dir[k];
			ev[k][EV_BDN] = m_b & ~(ud & dir[k]);
			upd_ld[k] = ev_zero[k] &
				(~gctl[k][CTL_LOAD_SYNC] | upd_armed[k]);
			upd_a[k] = ev_zero[k] &
				(~gctl[k][CTL_CMPA_SYNC] | upd_armed[k]);
			upd_b[k] = ev_zero[k] &
				(~gctl[k][CTL_CMPB_SYNC] | upd_armed[k]);
			eff_load[k] = upd_ld[k] ? load_sh[k] : load_act[k];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int k = 0; k < NUM_GEN; k++) begin
				load_act[k] <= '0;
				cmpa_act[k] <= '0;
				cmpb_act[k] <= '0;
			end
		end else begin
			for (int k = 0; k < NUM_GEN; k++) begin
				if (upd_ld[k]) load_act[k] <= load_sh[k];
				if (upd_a[k]) cmpa_act[k] <= cmpa_sh[k];
				if (upd_b[k]) cmpb_act[k] <= cmpb_sh[k];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Counters; a halted counter sits at zero and fires no events
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt <= '{default: '0};
			dir <= '0;
			halted <= '0;
		end else begin
			for (int k = 0; k < NUM_GEN; k++) begin
				if (!stall_s) begin
					halted[k] <= 1'b0;
				end else if (ev_zero[k] && !gctl[k][CTL_DBG_RUN]) begin
					halted[k] <= 1'b1;
				end
				if (sync_rst[k]) begin
					cnt[k] <= '0;
					dir[k] <= 1'b0;
				end else if (stall_s && ev_zero[k] &&
					!gctl[k][CTL_DBG_RUN]) begin
					// No reload on the halting zero, so it parks at zero
					cnt[k] <= '0;
				end else if (run[k] && !gctl[k][CTL_UPDOWN]) begin
					dir[k] <= 1'b0;
					cnt[k] <= (cnt[k] == '0) ? eff_load[k] :
						cnt[k] - 16'h0001;
				end else if (run[k] && dir[k]) begin
					if (cnt[k] >= load_act[k]) begin
						dir[k] <= 1'b0;
						cnt[k] <= (cnt[k] == '0) ? '0 : cnt[k] - 16'h0001;
					end else begin
						cnt[k] <= cnt[k] + 16'h0001;
					end
				end else if (run[k]) begin
					if (cnt[k] == '0) begin
						dir[k] <= 1'b1;
						cnt[k] <= (eff_load[k] == '0) ? '0 : 16'h0001;
					end else begin
						cnt[k] <= cnt[k] - 16'h0001;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Signal generator
	always_comb begin
		logic za, zb, ev_a, ev_b;
		logic [1:0] act_a, act_b;
		za = 1'b0;
		zb = 1'b0;
		ev_a = 1'b0;
		ev_b = 1'b0;
		act_a = ACT_NONE;
		act_b = ACT_NONE;
		for (int k = 0; k < NUM_GEN; k++) begin
			za = gen_a[k];
			zb = gen_b[k];
			za = ev[k][EV_ZERO] ? apply_act(gena[k][1:0], za) : za;
			zb = ev[k][EV_ZERO] ? apply_act(genb[k][1:0], zb) : zb;
			za = ev[k][EV_LOAD] ? apply_act(gena[k][3:2], za) : za;
			zb = ev[k][EV_LOAD] ? apply_act(genb[k][3:2], zb) : zb;
			// Compare events lose to zero or load
			ev_a = (ev[k][EV_AUP] | ev[k][EV_ADN]) &
				~ev[k][EV_ZERO] & ~ev[k][EV_LOAD];
			ev_b = (ev[k][EV_BUP] | ev[k][EV_BDN]) &
				~ev[k][EV_ZERO] & ~ev[k][EV_LOAD];
			act_a = ev[k][EV_AUP] ? gena[k][5:4] : gena[k][7:6];
			if (!ev_a) begin
				act_a = ev[k][EV_BUP] ? gena[k][9:8] : gena[k][11:10];
			end
			act_b = ev[k][EV_BUP] ? genb[k][9:8] : genb[k][11:10];
			if (!ev_b) begin
				act_b = ev[k][EV_AUP] ? genb[k][5:4] : genb[k][7:6];
			end
			// Each output prefers its own comparator when both hit
			next_gen_a[k] = (ev_a | ev_b) ? apply_act(act_a, za) : za;
			next_gen_b[k] = (ev_a | ev_b) ? apply_act(act_b, zb) : zb;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			gen_a <= '0;
			gen_b <= '0;
		end else begin
			gen_a <= next_gen_a;
			gen_b <= next_gen_b;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Dead-band: counters saturate, so a shrunk delay still ends
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_r <= '{default: '0};
			cnt_f <= '{default: '0};
		end else begin
			for (int k = 0; k < NUM_GEN; k++) begin
				if (!gen_a[k]) begin
					cnt_r[k] <= '0;
				end else if (cnt_r[k] < db_rise[k]) begin
					cnt_r[k] <= cnt_r[k] + 12'h001;
				end
				if (gen_a[k]) begin
					cnt_f[k] <= '0;
				end else if (cnt_f[k] < db_fall[k]) begin
					cnt_f[k] <= cnt_f[k] + 12'h001;
				end
			end
		end
	end

	always_comb begin
		for (int k = 0; k < NUM_GEN; k++) begin
			raw_out[2*k] = db_en[k] ?
				(gen_a[k] & (cnt_r[k] >= db_rise[k])) : gen_a[k];
			raw_out[2*k+1] = db_en[k] ?
				(~gen_a[k] & (cnt_f[k] >= db_fall[k])) :
				gen_b[k];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output stage and interrupt lines
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_pwm <= '0;
		end else begin
			for (int i = 0; i < NUM_OUT; i++) begin
				o_pwm[i] <= out_en[i] & ((raw_out[i] &
					~(fault_en[i] & fault_s)) ^ out_inv[i]);
			end
		end
	end

	always_comb begin
		for (int k = 0; k < NUM_GEN; k++) begin
			o_gen_irq[k] = glob_ien[k] & (|(gris[k] & gien[k]));
		end
	end
	assign o_fault_irq = fault_ien & fault_ris;
endmodule

// ---- test/pwm_unit_chk.sv ----
`timescale 1ns/1ps
module pwm_unit_chk (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_s_axi_awvalid,
	input wire logic o_s_axi_awready,
	input wire logic i_s_axi_wvalid,
	input wire logic o_s_axi_wready,
	input wire logic [1:0] o_s_axi_bresp,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic [1:0] o_s_axi_rresp,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	input wire logic i_fault,
	input wire logic [5:0] o_pwm,
	input wire logic [2:0] o_gen_irq,
	input wire logic o_fault_irq
);
	logic cfg_seen;
	logic [3:0] flt_age;
	always_ff @(posedge i_clk) begin
		if (i_rst)
			cfg_seen <= 1'b0;
		else
			cfg_seen <= cfg_seen | o_s_axi_bvalid;
	end
	// Saturating age of the last fault sample, covers the pin synchroniser
	always_ff @(posedge i_clk) begin
		if (i_rst || i_fault)
			flt_age <= i_rst ? 4'hf : 4'h0;
		else if (flt_age != 4'hf)
			flt_age <= flt_age + 4'h1;
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	a_bresp_okay: assert property (
		o_s_axi_bvalid |-> o_s_axi_bresp == 2'h0) else $error("bad bresp");
	a_bvalid_hold: assert property (
		o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
		else $error("bvalid dropped");
	a_wr_answer: assert property (i_s_axi_awvalid && o_s_axi_awready &&
		i_s_axi_wvalid && o_s_axi_wready |-> ##[2:4] o_s_axi_bvalid)
		else $error("no write response");
	a_rd_answer: assert property (i_s_axi_arvalid && o_s_axi_arready
		|=> o_s_axi_rvalid && o_s_axi_rresp == 2'h0)
		else $error("no read response");
	a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
		|=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data not held");
	a_arready_rule: assert property (o_s_axi_arready == !o_s_axi_rvalid)
		else $error("arready wrong");
	a_pins_idle: assert property (
		!cfg_seen |-> o_pwm == 6'h00 && o_gen_irq == 3'h0)
		else $error("output active before setup");
	a_fault_cause: assert property (
		$rose(o_fault_irq) |-> flt_age < 4'h8 || o_s_axi_bvalid)
		else $error("fault irq without fault");
	a_rst_clears: assert property (
		disable iff (1'b0) i_rst |=> o_pwm == 6'h00 && !o_s_axi_bvalid
		&& !o_s_axi_rvalid) else $error("reset left outputs set");
endmodule
bind multi_generator_pwm_unit pwm_unit_chk chk (.*);

// ---- test/gate_driver_model.sv ----
`timescale 1ns/1ps
module gate_driver_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [5:0] i_gate,
	output logic [2:0] o_shoot
);
	// Both gates of one leg on shorts the supply; latch it for the bench
	always_ff @(posedge i_clk) begin
		for (int k = 0; k < 3; k++) begin
			if (i_rst)
				o_shoot[k] <= 1'b0;
			else if (i_gate[2*k] && i_gate[2*k+1])
				o_shoot[k] <= 1'b1;
		end
	end
endmodule

// ---- test/multi_generator_pwm_unit_tb.sv ----
`timescale 1ns/1ps
module multi_generator_pwm_unit_tb;
	import pwm_unit_pkg::*;
	logic i_clk, i_rst, awv, wv, bry, arv, rry, flt, stl;
	logic [11:0] awa, ara;
	logic [31:0] wd, rd;
	logic [3:0] ws;
	logic awr, wr, bv, arr, rv, firq;
	logic [1:0] br, rr;
	logic [5:0] pwm;
	logic [2:0] girq, shoot;
	logic [31:0] expq[$];
	logic [15:0] lf;
	int n_fail, tests_run;
	multi_generator_pwm_unit uut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_s_axi_awaddr(awa),
		.i_s_axi_awvalid(awv),
		.o_s_axi_awready(awr),
		.i_s_axi_wdata(wd),
		.i_s_axi_wstrb(ws),
		.i_s_axi_wvalid(wv),
		.o_s_axi_wready(wr),
		.o_s_axi_bresp(br),
		.o_s_axi_bvalid(bv),
		.i_s_axi_bready(bry),
		.i_s_axi_araddr(ara),
		.i_s_axi_arvalid(arv),
		.o_s_axi_arready(arr),
		.o_s_axi_rdata(rd),
		.o_s_axi_rresp(rr),
		.o_s_axi_rvalid(rv),
		.i_s_axi_rready(rry),
		.i_fault(flt),
		.i_stall(stl),
		.o_pwm(pwm),
		.o_gen_irq(girq),
		.o_fault_irq(firq)
	);
	gate_driver_model gdm (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_gate(pwm),
		.o_shoot(shoot)
	);
	initial begin
		i_clk = 0;
		forever #10 i_clk = ~i_clk;
	end
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test;
		$display("Checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [11:0] ga(input int g, input logic [5:0] o);
		return 12'(64 * (g + 1)) + {6'h00, o};
	endfunction
	// Ready is judged at the falling edge so the decision never races
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		logic ad, dd;
		ad = 0;
		dd = 0;
		awa <= a;
		wd <= d;
		ws <= 4'hf;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		while (!(ad && dd)) begin
			@(negedge i_clk);
			ad = ad | (awv & awr);
			dd = dd | (wv & wr);
			@(posedge i_clk);
			if (ad) awv <= 0;
			if (dd) wv <= 0;
		end
		do @(negedge i_clk); while (bv !== 1'b1);
		chk("bresp", RESP_OKAY, br);
		@(posedge i_clk);
		bry <= 0;
		@(posedge i_clk);
	endtask
	task automatic rd_reg(input logic [11:0] a, input logic [31:0] e);
		logic ad;
		ad = 0;
		ara <= a;
		arv <= 1;
		rry <= 1;
		expq.push_back(e);
		while (!ad) begin
			@(negedge i_clk);
			ad = arv & arr;
			@(posedge i_clk);
			if (ad) arv <= 0;
		end
		do @(negedge i_clk); while (rv !== 1'b1);
		@(posedge i_clk);
		rry <= 0;
		@(posedge i_clk);
	endtask
	always @(negedge i_clk) begin
		if (rv === 1'b1 && rry === 1'b1)
			chk("rdata", expq.pop_front(), rd);
	end
	task automatic cfg(input int g, input logic [15:0] ld, ca, cb,
		input logic [31:0] a, b, ct);
		wr_reg(ga(g, GOFS_LOAD), {16'h0, ld});
		wr_reg(ga(g, GOFS_CMPA), {16'h0, ca});
		wr_reg(ga(g, GOFS_CMPB), {16'h0, cb});
		wr_reg(ga(g, GOFS_GENA), a);
		wr_reg(ga(g, GOFS_GENB), b);
		wr_reg(ga(g, GOFS_CTL), ct);
	endtask
	// Duty is counted, so the fixed pin latency drops out
	task automatic duty(input int p, input int n, input int e);
		int c;
		c = 0;
		repeat (n) begin
			@(negedge i_clk);
			c += (pwm[p] === 1'b1) ? 1 : ((pwm[p] === 1'b0) ? 0 : 1000);
		end
		chk("pin high count", e, c);
		@(posedge i_clk);
	endtask
	task automatic irqs(input logic [2:0] eg, input logic ef);
		@(negedge i_clk);
		chk("gen irq", eg, girq);
		chk("fault irq", ef, firq);
		@(posedge i_clk);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge i_clk);
		n_fail++;
		stop_test();
	end
	initial begin
		{i_rst, awv, wv, bry, arv, rry, flt, stl} = 8'h80;
		{awa, ara, wd, ws} = '0;
		n_fail = 0;
		tests_run = 0;
		lf = 16'h004f;
		repeat (4) @(posedge i_clk);
		i_rst <= 0;
		@(posedge i_clk);
		rd_reg(OFS_ENABLE, 0);
		rd_reg(ga(0, GOFS_LOAD), 0);
		rd_reg(ga(1, GOFS_GENA), 0);
		rd_reg(12'h100, 0);
		cfg(0, 16'h4, 16'h2, 16'h0, 32'h83, 32'hc00, 32'h1);
		cfg(1, 16'h4, 16'h2, 16'h5, 32'hb0, 32'h300, 32'h3);
		wr_reg(ga(2, GOFS_DBCTL), 1);
		wr_reg(ga(2, GOFS_DBRISE), 2);
		wr_reg(ga(2, GOFS_DBFALL), 1);
		cfg(2, 16'h9, 16'h5, 16'h0, 32'h83, 32'hfff, 32'h1);
		wr_reg(OFS_ENABLE, 32'h3f);
		repeat (20) @(posedge i_clk);
		duty(0, 25, 15);
		duty(1, 25, 0);
		duty(2, 32, 16);
		duty(3, 32, 0);
		duty(4, 30, 9);
		duty(5, 30, 12);
		chk("shoot through", 0, shoot[2]);
		wr_reg(ga(0, GOFS_CMPA), 1);
		rd_reg(ga(0, GOFS_CMPA), 1);
		repeat (10) @(posedge i_clk);
		duty(0, 25, 20);
		wr_reg(ga(0, GOFS_CTL), 32'h11);
		wr_reg(ga(0, GOFS_CMPA), 3);
		repeat (10) @(posedge i_clk);
		duty(0, 25, 20);
		wr_reg(OFS_CTL, 1);
		repeat (10) @(posedge i_clk);
		duty(0, 25, 10);
		rd_reg(OFS_CTL, 0);
		wr_reg(ga(0, GOFS_INTEN), 1);
		wr_reg(OFS_INTEN, 32'h10001);
		repeat (10) @(posedge i_clk);
		irqs(3'h1, 0);
		wr_reg(OFS_INTEN, 32'h10000);
		irqs(3'h0, 0);
		wr_reg(OFS_FAULT, 32'h04);
		flt <= 1;
		repeat (10) @(posedge i_clk);
		duty(2, 32, 0);
		irqs(3'h0, 1);
		flt <= 0;
		repeat (10) @(posedge i_clk);
		duty(2, 32, 16);
		wr_reg(OFS_ISC, 32'h10000);
		irqs(3'h0, 0);
		wr_reg(ga(1, GOFS_CTL), 32'h7);
		stl <= 1;
		repeat (20) @(posedge i_clk);
		duty(0, 25, 25);
		duty(2, 32, 16);
		wr_reg(ga(0, GOFS_ISC), 32'h3f);
		wr_reg(OFS_INTEN, 32'h10001);
		repeat (5) @(posedge i_clk);
		irqs(3'h0, 0);
		rd_reg(ga(0, GOFS_RIS), 0);
		rd_reg(ga(0, GOFS_COUNT), 0);
		stl <= 0;
		repeat (10) @(posedge i_clk);
		irqs(3'h1, 0);
		repeat (3) begin
			lf = nx(lf);
			wr_reg(ga(2, GOFS_CMPB), {16'h0, lf});
			rd_reg(ga(2, GOFS_CMPB), {16'h0, lf});
		end
		wr_reg(OFS_ENABLE, 32'h3e);
		wr_reg(OFS_INVERT, 32'h03);
		repeat (5) @(posedge i_clk);
		duty(0, 25, 0);
		duty(1, 25, 25);
		wr_reg(OFS_SYNC, 32'h5);
		rd_reg(ga(0, GOFS_COUNT), 32'h4);
		rd_reg(ga(2, GOFS_COUNT), 32'h6);
		stop_test();
	end
endmodule
